// >>> core/logic_bit_op_pkg.sv
// Constants, register map and carrier types for the logic and bit-op datapath.
// Assumes a 32-bit APB master and one 125 MHz system clock.
package logic_bit_op_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned BIT_W  = 3;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] WORK_OFS  = 8'h00;
   localparam logic [ADDR_W-1:0] FLAG_OFS  = 8'h04;
   localparam logic [ADDR_W-1:0] LATCH_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] DIR_OFS   = 8'h0C;
   localparam logic [ADDR_W-1:0] PIN_OFS   = 8'h10;
   localparam logic [ADDR_W-1:0] STAT_OFS  = 8'h14;

   // Values after reset
   localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
   localparam logic [3:0]        FLAG_RST  = 4'h0;
   localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
   localparam logic [DATA_W-1:0] DIR_RST   = 8'h00;
   localparam logic [15:0]       CNT_RST   = 16'h0000;

   // Flag register fields
   localparam int unsigned FLAG_Z_POS  = 0;
   localparam int unsigned FLAG_C_POS  = 1;
   localparam int unsigned FLAG_HB_POS = 2;
   localparam int unsigned FLAG_SW_POS = 3;

   // Status register fields
   localparam int unsigned STAT_CNT_POS = 0;
   localparam int unsigned STAT_OP_POS  = 16;

   typedef enum logic [3:0] {
      OP_XOR_AM = 4'h0,
      OP_XOR_MA = 4'h1,
      OP_NOT_A  = 4'h2,
      OP_NOT_M  = 4'h3,
      OP_NEG_A  = 4'h4,
      OP_NEG_M  = 4'h5,
      OP_CMP_AI = 4'h6,
      OP_CMP_AM = 4'h7,
      OP_CMP_MA = 4'h8,
      OP_CLR_IO = 4'h9,
      OP_SET_IO = 4'hA,
      OP_TOG_IO = 4'hB,
      OP_CLR_M  = 4'hC,
      OP_SET_M  = 4'hD,
      OP_SWAPC  = 4'hE,
      OP_NONE   = 4'hF
   } op_t;

   typedef struct packed {
      logic signed_wrap_flag;
      logic half_borrow_flag;
      logic carry;
      logic zero;
   } flags_t;

   typedef struct packed {
      op_t              op;
      logic [BIT_W-1:0] bit_sel;
      logic [7:0]       imm;
   } cmd_t;

   typedef struct packed {
      logic        we;
      logic [7:0]  data;
   } mem_wr_t;

endpackage

// >>> core/logic_bit_op_datapath.sv
// Logic and bit-manipulation datapath of the 8-bit controller, APB register slave.
// Assumes the decoder presents one command with its memory byte in the same cycle.
//
// Contract
// - XOR memory into working register, zero only
// - XOR result written back to memory, zero only
// - Invert working register, zero flag only
// - Invert memory byte, zero flag only
// - Negate working register modulo 256, zero only
// - Negate memory byte modulo 256, zero only
// - Compare with immediate sets four flags only
// - Compare register minus memory, four flags only
// - Compare memory minus register, four flags only
// - Carry is bit-7 borrow, half is nibble borrow
// - Clear port bit n, flags kept
// - Force port bit n high, flags kept
// - Toggle port bit n, flags kept
// - Clear memory bit n, flags kept
// - Force memory bit n high, flags kept
// - Swap port bit with carry, carry only
// - Output bit takes carry value
// - Input bit pin level loads carry
`timescale 1ns/10ps

module logic_bit_op_datapath #(
   parameter int unsigned DATA_W = logic_bit_op_pkg::DATA_W
) (
   input  wire logic                                clk_i,
   input  wire logic                                resetn_i,
   // Decoder command
   input  wire logic                                cmd_valid_i,
   input  wire logic_bit_op_pkg::cmd_t              cmd_i,
   output logic                                     cmd_ready_o,
   output logic                                     done_o,
   // Data memory
   input  wire logic [DATA_W-1:0]                   mem_rdata_i,
   output logic_bit_op_pkg::mem_wr_t                mem_wr_o,
   // Core state
   output logic [DATA_W-1:0]                        working_register_o,
   output logic_bit_op_pkg::flags_t                 flags_o,
   // Port pins
   input  wire logic [DATA_W-1:0]                   port_pin_i,
   output logic [DATA_W-1:0]                        port_pin_o,
   output logic [DATA_W-1:0]                        port_pin_oe_o,
   // APB slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [logic_bit_op_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                         pwdata,
   output logic [31:0]                              prdata,
   output logic                                     pready,
   output logic                                     pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic [DATA_W-1:0]                 work_q;
   logic_bit_op_pkg::flags_t          flags_q;
   logic [DATA_W-1:0]                 port_a_latch_q;
   logic [DATA_W-1:0]                 dir_q;
   logic [DATA_W-1:0]                 pin_meta_q;
   logic [DATA_W-1:0]                 pin_sync_q;
   logic_bit_op_pkg::mem_wr_t         mem_wr_q;
   logic                              done_q;
   logic [15:0]                       op_cnt_q;
   logic_bit_op_pkg::op_t             last_op_q;
   logic [31:0]                       prdata_q;
   logic                              pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, two stages per bit
   // Pins are asynchronous; only the second stage feeds logic

   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_pin_sync
         always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
               pin_meta_q[gi] <= 1'b0;
               pin_sync_q[gi] <= 1'b0;
            end else begin
               pin_meta_q[gi] <= port_pin_i[gi];
               pin_sync_q[gi] <= pin_meta_q[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection and arithmetic

   logic                              go;
   logic [DATA_W-1:0]                 acc;
   logic [DATA_W-1:0]                 mem;
   logic [DATA_W-1:0]                 mask;
   logic [DATA_W-1:0]                 lhs;
   logic [DATA_W-1:0]                 rhs;
   logic [DATA_W:0]                   diff;
   logic [DATA_W-1:0]                 res;
   logic                              sel_dir;
   logic                              sel_latch;
   logic                              sel_pin;

   // Always ready, so every valid strobe is an accepted command
   assign go        = cmd_valid_i;
   assign acc       = work_q;
   assign mem       = mem_rdata_i;
   // One-hot bit select shared by the clear, set and toggle bit operations; the carry swap indexes bit_sel directly
   assign mask      = DATA_W'(1) << cmd_i.bit_sel;
   assign sel_dir   = dir_q[cmd_i.bit_sel];
   assign sel_latch = port_a_latch_q[cmd_i.bit_sel];
   assign sel_pin   = pin_sync_q[cmd_i.bit_sel];

   always_comb begin
      case (cmd_i.op)
         logic_bit_op_pkg::OP_CMP_AI: begin
            lhs = acc;
            rhs = cmd_i.imm[DATA_W-1:0];
         end
         logic_bit_op_pkg::OP_CMP_MA: begin
            lhs = mem;
            rhs = acc;
         end
         default: begin
            lhs = acc;
            rhs = mem;
         end
      endcase
   end

   // One extra bit catches the borrow out of bit 7
   assign diff = {1'b0, lhs} - {1'b0, rhs};

   always_comb begin
      case (cmd_i.op)
         logic_bit_op_pkg::OP_XOR_AM: res = acc ^ mem;
         logic_bit_op_pkg::OP_XOR_MA: res = acc ^ mem;
         logic_bit_op_pkg::OP_NOT_A:  res = ~acc;
         logic_bit_op_pkg::OP_NOT_M:  res = ~mem;
         logic_bit_op_pkg::OP_NEG_A:  res = DATA_W'(0) - acc;
         logic_bit_op_pkg::OP_NEG_M:  res = DATA_W'(0) - mem;
         logic_bit_op_pkg::OP_CLR_M:  res = mem & ~mask;
         logic_bit_op_pkg::OP_SET_M:  res = mem | mask;
         default:                     res = diff[DATA_W-1:0];
      endcase
   end

   // Which state each operation may touch
   logic is_cmp;
   logic is_zonly;
   logic is_mem_wr;

   always_comb begin
      is_cmp    = 1'b0;
      is_zonly  = 1'b0;
      is_mem_wr = 1'b0;
      case (cmd_i.op)
         logic_bit_op_pkg::OP_XOR_AM,
         logic_bit_op_pkg::OP_NOT_A,
         logic_bit_op_pkg::OP_NEG_A: begin
            is_zonly = 1'b1;
         end
         logic_bit_op_pkg::OP_XOR_MA,
         logic_bit_op_pkg::OP_NOT_M,
         logic_bit_op_pkg::OP_NEG_M: begin
            is_zonly  = 1'b1;
            is_mem_wr = 1'b1;
         end
         logic_bit_op_pkg::OP_CMP_AI,
         logic_bit_op_pkg::OP_CMP_AM,
         logic_bit_op_pkg::OP_CMP_MA: begin
            is_cmp = 1'b1;
         end
         logic_bit_op_pkg::OP_CLR_M,
         logic_bit_op_pkg::OP_SET_M: begin
            is_mem_wr = 1'b1;
         end
         default: begin
            is_cmp = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic apb_wr;
   logic apb_setup;
   logic addr_hit;

   assign apb_wr    = psel && penable && pwrite;
   assign apb_setup = psel && !penable;

   always_comb begin
      case (paddr)
         logic_bit_op_pkg::WORK_OFS,
         logic_bit_op_pkg::FLAG_OFS,
         logic_bit_op_pkg::LATCH_OFS,
         logic_bit_op_pkg::DIR_OFS,
         logic_bit_op_pkg::PIN_OFS,
         logic_bit_op_pkg::STAT_OFS: addr_hit = 1'b1;
         default:                    addr_hit = 1'b0;
      endcase
   end

   logic wr_work;
   logic wr_flag;
   logic wr_latch;
   logic wr_dir;

   // Read-only and unmapped offsets get no strobe, so writes there vanish
   assign wr_work  = apb_wr && (paddr == logic_bit_op_pkg::WORK_OFS);
   assign wr_flag  = apb_wr && (paddr == logic_bit_op_pkg::FLAG_OFS);
   assign wr_latch = apb_wr && (paddr == logic_bit_op_pkg::LATCH_OFS);
   assign wr_dir   = apb_wr && (paddr == logic_bit_op_pkg::DIR_OFS);

   logic [31:0] rd_word;

   // Whole read word built here; the capture flop stays a plain register
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         logic_bit_op_pkg::WORK_OFS:  rd_word[DATA_W-1:0] = work_q;
         logic_bit_op_pkg::FLAG_OFS:  rd_word[3:0]        = flags_q;
         logic_bit_op_pkg::LATCH_OFS: rd_word[DATA_W-1:0] = port_a_latch_q;
         logic_bit_op_pkg::DIR_OFS:   rd_word[DATA_W-1:0] = dir_q;
         logic_bit_op_pkg::PIN_OFS:   rd_word[DATA_W-1:0] = pin_sync_q;
         logic_bit_op_pkg::STAT_OFS: begin
            rd_word[logic_bit_op_pkg::STAT_CNT_POS +: 16] = op_cnt_q;
            rd_word[logic_bit_op_pkg::STAT_OP_POS +: 4]   = last_op_q;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Working register; a command beats a software write in the same cycle

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         work_q <= logic_bit_op_pkg::WORK_RST;
      end else if (go && (cmd_i.op == logic_bit_op_pkg::OP_XOR_AM ||
                          cmd_i.op == logic_bit_op_pkg::OP_NOT_A ||
                          cmd_i.op == logic_bit_op_pkg::OP_NEG_A)) begin
         work_q <= res;
      end else if (wr_work) begin
         work_q <= pwdata[DATA_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         flags_q <= logic_bit_op_pkg::FLAG_RST;
      end else if (go && is_zonly) begin
         flags_q.zero <= (res == DATA_W'(0));
      end else if (go && is_cmp) begin
         flags_q.zero             <= (diff[DATA_W-1:0] == DATA_W'(0));
         flags_q.carry            <= diff[DATA_W];
         // Half borrow looks at the low nibbles alone
         flags_q.half_borrow_flag <= (lhs[3:0] < rhs[3:0]);
         // Signed wrap: operand signs differ and result sign leaves lhs
         flags_q.signed_wrap_flag <= (lhs[DATA_W-1] ^ rhs[DATA_W-1]) &
                                     (lhs[DATA_W-1] ^ diff[DATA_W-1]);
      end else if (go && cmd_i.op == logic_bit_op_pkg::OP_SWAPC) begin
         flags_q.carry <= sel_dir ? sel_latch : sel_pin;
      end else if (wr_flag) begin
         flags_q.zero             <= pwdata[logic_bit_op_pkg::FLAG_Z_POS];
         flags_q.carry            <= pwdata[logic_bit_op_pkg::FLAG_C_POS];
         flags_q.half_borrow_flag <= pwdata[logic_bit_op_pkg::FLAG_HB_POS];
         flags_q.signed_wrap_flag <= pwdata[logic_bit_op_pkg::FLAG_SW_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port latch and direction

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         port_a_latch_q <= logic_bit_op_pkg::LATCH_RST;
      end else if (go && cmd_i.op == logic_bit_op_pkg::OP_CLR_IO) begin
         port_a_latch_q <= port_a_latch_q & ~mask;
      end else if (go && cmd_i.op == logic_bit_op_pkg::OP_SET_IO) begin
         port_a_latch_q <= port_a_latch_q | mask;
      end else if (go && cmd_i.op == logic_bit_op_pkg::OP_TOG_IO) begin
         port_a_latch_q <= port_a_latch_q ^ mask;
      end else if (go && cmd_i.op == logic_bit_op_pkg::OP_SWAPC) begin
         // Latch takes carry either way; only an output bit shows it
         port_a_latch_q[cmd_i.bit_sel] <= flags_q.carry;
      end else if (wr_latch) begin
         port_a_latch_q <= pwdata[DATA_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         dir_q <= logic_bit_op_pkg::DIR_RST;
      end else if (wr_dir) begin
         dir_q <= pwdata[DATA_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory write-back, one cycle after the command

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mem_wr_q <= '0;
      end else begin
         mem_wr_q.we   <= go && is_mem_wr;
         // Data runs free; only the strobe says it is meant
         mem_wr_q.data <= res;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion and status

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         done_q <= 1'b0;
      end else begin
         // The no-op code still pulses done
         done_q <= go;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         op_cnt_q  <= logic_bit_op_pkg::CNT_RST;
         last_op_q <= logic_bit_op_pkg::OP_NONE;
      end else if (go) begin
         op_cnt_q  <= op_cnt_q + 16'h0001;
         last_op_q <= cmd_i.op;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read data, captured in the setup cycle

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         pslverr_q <= !addr_hit;
         prdata_q  <= rd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Every operation finishes in one cycle, so no stall
   assign cmd_ready_o        = 1'b1;
   assign done_o             = done_q;
   assign mem_wr_o           = mem_wr_q;
   assign working_register_o = work_q;
   assign flags_o            = flags_q;
   assign port_pin_o         = port_a_latch_q;
   assign port_pin_oe_o      = dir_q;
   // Stale read data would be one setup late; slave never waits
   assign pready             = 1'b1;
   assign prdata             = prdata_q;
   assign pslverr            = pslverr_q;

endmodule // logic_bit_op_datapath

// >>> dv/far_side_model.sv
// Far side of the datapath: one data memory byte and the port pins.
// Assumes the bench presets the byte and sets the outside pin levels.
`timescale 1ns/10ps

module far_side_model (
   input  wire logic                      clk_i,
   input  wire logic                      preset_i,
   input  wire logic [7:0]                preset_data_i,
   input  wire logic_bit_op_pkg::mem_wr_t mem_wr_i,
   input  wire logic [7:0]                ext_level_i,
   input  wire logic [7:0]                pin_drive_i,
   input  wire logic [7:0]                pin_oe_i,
   output logic [7:0]                     mem_byte_o,
   output logic [7:0]                     pin_level_o
);
   logic [7:0] mem_q;

   always_ff @(posedge clk_i) begin
      if (preset_i) begin
         mem_q <= preset_data_i;
      end else if (mem_wr_i.we) begin
         mem_q <= mem_wr_i.data;
      end
   end

   assign mem_byte_o = mem_q;
   // Driven bits follow the latch, released bits follow the outside world
   assign pin_level_o = (pin_drive_i & pin_oe_i) | (ext_level_i & ~pin_oe_i);
endmodule // far_side_model

// >>> dv/logic_bit_op_properties.sv
// Concurrent checks on the command results seen at the datapath ports.
// Assumes no APB write overlaps a command.
`timescale 1ns/10ps

module logic_bit_op_properties #(
   parameter int unsigned DATA_W = logic_bit_op_pkg::DATA_W
) (
   input wire logic                      clk_i,
   input wire logic                      resetn_i,
   input wire logic                      cmd_valid_i,
   input wire logic_bit_op_pkg::cmd_t    cmd_i,
   input wire logic [DATA_W-1:0]         mem_rdata_i,
   input wire logic_bit_op_pkg::mem_wr_t mem_wr_o,
   input wire logic [DATA_W-1:0]         working_register_o,
   input wire logic_bit_op_pkg::flags_t  flags_o,
   input wire logic [DATA_W-1:0]         port_pin_o
);
   logic [15:0] hit;

   assign hit = cmd_valid_i ? 16'h0001 << cmd_i.op : 16'h0000;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   ////////////////////////////////////////////////////////////////////////////
   a_xor_into_work: assert property (hit[logic_bit_op_pkg::OP_XOR_AM] |=>
      working_register_o == ($past(working_register_o) ^ $past(mem_rdata_i))
      && $stable(flags_o[3:1])) else $error("xor into register wrong");
   a_xor_to_mem: assert property (hit[logic_bit_op_pkg::OP_XOR_MA] |=>
      mem_wr_o.we && mem_wr_o.data == ($past(working_register_o) ^ $past(mem_rdata_i)))
      else $error("xor to memory wrong");
   a_invert_work: assert property (hit[logic_bit_op_pkg::OP_NOT_A] |=>
      working_register_o == ~$past(working_register_o) && $stable(flags_o[3:1]))
      else $error("register invert wrong");
   a_negate_mem: assert property (hit[logic_bit_op_pkg::OP_NEG_M] |=>
      mem_wr_o.we && mem_wr_o.data == 8'h00 - $past(mem_rdata_i))
      else $error("memory negate wrong");
   a_cmp_no_write: assert property (|hit[8:6] |=>
      !mem_wr_o.we && $stable(working_register_o)) else $error("compare wrote");
   a_cmp_borrow: assert property (hit[logic_bit_op_pkg::OP_CMP_AI] |=>
      flags_o.carry == ($past(working_register_o) < $past(cmd_i.imm))
      && flags_o.zero == ($past(working_register_o) == $past(cmd_i.imm)))
      else $error("compare carry or zero wrong");
   a_bitop_flags: assert property (|hit[13:9] |=> $stable(flags_o))
      else $error("bit operation moved flags");
   a_toggle_one_bit: assert property (hit[logic_bit_op_pkg::OP_TOG_IO] |=>
      (port_pin_o ^ $past(port_pin_o)) == (8'h01 << $past(cmd_i.bit_sel)))
      else $error("toggle changed wrong bits");
   a_clear_io_bit: assert property (hit[logic_bit_op_pkg::OP_CLR_IO] |=>
      port_pin_o == ($past(port_pin_o) & ~(8'h01 << $past(cmd_i.bit_sel))))
      else $error("port bit clear wrong");
   a_swap_carry: assert property (hit[logic_bit_op_pkg::OP_SWAPC] |=>
      $stable(flags_o.zero) && $stable(flags_o[3:2])
      && port_pin_o[$past(cmd_i.bit_sel)] == $past(flags_o.carry))
      else $error("carry swap wrong");
endmodule // logic_bit_op_properties

bind logic_bit_op_datapath logic_bit_op_properties #(.DATA_W(DATA_W)) u_props (
   .clk_i, .resetn_i, .cmd_valid_i, .cmd_i, .mem_rdata_i, .mem_wr_o,
   .working_register_o, .flags_o, .port_pin_o);

// >>> dv/logic_bit_op_datapath_tb_top.sv
// Self-checking bench: APB sets up state, one command runs, ports compared.
// Assumes far_side_model supplies the memory byte and pin levels.
`timescale 1ns/10ps

module logic_bit_op_datapath_tb_top;
   logic                      clk_i, resetn_i, cmd_valid_i, cmd_ready_o, done_o;
   logic                      psel, penable, pwrite, pready, pslverr, preset, rd_err, e_we;
   logic_bit_op_pkg::cmd_t    cmd_i;
   logic_bit_op_pkg::mem_wr_t mem_wr_o;
   logic_bit_op_pkg::flags_t  flags_o;
   logic [7:0]                paddr, mem_rdata_i, working_register_o, mdata, ext;
   logic [7:0]                port_pin_i, port_pin_o, port_pin_oe_o;
   logic [7:0]                acc, lat, dir, mem, pin, e_acc, e_lat, e_md;
   logic [31:0]               pwdata, prdata, rd;
   logic [3:0]                fl, e_fl;
   logic [7:0]                cmp_imm [4] = '{8'h38, 8'h42, 8'h24, 8'h6A};
   int                        err_total, samples_checked, seed;

   logic_bit_op_datapath dut (.clk_i, .resetn_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
      .done_o, .mem_rdata_i, .mem_wr_o, .working_register_o, .flags_o, .port_pin_i,
      .port_pin_o, .port_pin_oe_o, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   far_side_model far (.clk_i, .preset_i(preset), .preset_data_i(mdata),
      .mem_wr_i(mem_wr_o), .ext_level_i(ext), .pin_drive_i(port_pin_o),
      .pin_oe_i(port_pin_oe_o), .mem_byte_o(mem_rdata_i), .pin_level_o(port_pin_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (err_total == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      // No fixed latency is assumed; only the watchdog ends a wait
      while (pready !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic predict(input logic [3:0] op, input logic [2:0] n, input logic [7:0] imm);
      logic [8:0] df;
      logic [7:0] x;
      logic [7:0] y;
      e_acc = acc;
      e_fl = fl;
      e_lat = lat;
      e_md = 8'h00;
      case (op)
         logic_bit_op_pkg::OP_XOR_AM: e_acc = acc ^ mem;
         logic_bit_op_pkg::OP_XOR_MA: e_md = acc ^ mem;
         logic_bit_op_pkg::OP_NOT_A: e_acc = ~acc;
         logic_bit_op_pkg::OP_NOT_M: e_md = ~mem;
         logic_bit_op_pkg::OP_NEG_A: e_acc = 8'h00 - acc;
         logic_bit_op_pkg::OP_NEG_M: e_md = 8'h00 - mem;
         logic_bit_op_pkg::OP_CLR_IO: e_lat[n] = 1'b0;
         logic_bit_op_pkg::OP_SET_IO: e_lat[n] = 1'b1;
         logic_bit_op_pkg::OP_TOG_IO: e_lat[n] = ~lat[n];
         logic_bit_op_pkg::OP_CLR_M: e_md = mem & ~(8'h01 << n);
         logic_bit_op_pkg::OP_SET_M: e_md = mem | (8'h01 << n);
         logic_bit_op_pkg::OP_SWAPC: begin
            e_fl[1] = dir[n] ? lat[n] : pin[n];
            e_lat[n] = fl[1];
         end
         default: ;
      endcase
      e_we = op inside {4'h1, 4'h3, 4'h5, 4'hC, 4'hD};
      if (op inside {4'h0, 4'h2, 4'h4}) e_fl[0] = (e_acc == 8'h00);
      if (op inside {4'h1, 4'h3, 4'h5}) e_fl[0] = (e_md == 8'h00);
      if (op inside {4'h6, 4'h7, 4'h8}) begin
         x = (op == 4'h8) ? mem : acc;
         y = (op == 4'h6) ? imm : (op == 4'h7) ? mem : acc;
         df = {1'b0, x} - {1'b0, y};
         e_fl = {(x[7] ^ y[7]) & (df[7] ^ x[7]), x[3:0] < y[3:0], df[8], df[7:0] == 8'h00};
      end
   endtask

   task automatic run_op(input logic [3:0] op, input logic [2:0] n, input logic [7:0] imm);
      apb(1'b1, logic_bit_op_pkg::WORK_OFS, {24'h0, acc});
      apb(1'b1, logic_bit_op_pkg::FLAG_OFS, {28'h0, fl});
      apb(1'b1, logic_bit_op_pkg::LATCH_OFS, {24'h0, lat});
      apb(1'b1, logic_bit_op_pkg::DIR_OFS, {24'h0, dir});
      preset <= 1'b1;
      mdata <= mem;
      ext <= 8'($random(seed));
      @(posedge clk_i);
      preset <= 1'b0;
      // Pins pass a two-stage synchroniser before use
      repeat (3) @(posedge clk_i);
      pin = port_pin_i;
      cmd_valid_i <= 1'b1;
      cmd_i <= {op, n, imm};
      predict(op, n, imm);
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      #1;
      check(done_o, 1'b1);
      check({mem_wr_o.we, mem_wr_o.we ? mem_wr_o.data : 8'h00}, {e_we, e_md});
      check(working_register_o, e_acc);
      check(flags_o, e_fl);
      check(port_pin_o, e_lat);
      check(port_pin_oe_o, dir);
      @(posedge clk_i);
      #1;
      check({done_o, mem_wr_o.we}, 2'b00);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   initial begin
      repeat (30000) @(posedge clk_i);
      err_total++;
      tally_and_finish();
   end

   initial begin
      seed = 32'h2fcd;
      {resetn_i, cmd_valid_i, psel, penable, pwrite, preset} = 6'h00;
      {cmd_i, paddr, pwdata, mdata, ext} = '0;
      {acc, fl, lat, dir, mem} = '0;
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check(rd, (i == 5) ? 32'h000F_0000 : 32'h0);
      end
      apb(1'b0, 8'h18, 32'h0);
      check({rd_err, rd[30:0]}, 32'h8000_0000);
      check(cmd_ready_o, 1'b1);
      check(pready, 1'b1);
      acc = 8'h38;
      mem = 8'h38;
      foreach (cmp_imm[k]) run_op(logic_bit_op_pkg::OP_CMP_AI, 3'h0, cmp_imm[k]);
      for (int k = 2; k < 6; k++) run_op(4'(k), 3'h0, 8'h00);
      acc = 8'h00;
      run_op(logic_bit_op_pkg::OP_NEG_A, 3'h0, 8'h00);
      for (int i = 0; i < 128; i++) begin
         {acc, mem, lat} = 24'($random(seed));
         {dir, fl} = 12'($random(seed));
         run_op(4'(i), 3'($random(seed)), 8'($random(seed)));
      end
      apb(1'b0, logic_bit_op_pkg::STAT_OFS, 32'h0);
      check(rd, 32'h000F_0089);
      tally_and_finish();
   end
endmodule // logic_bit_op_datapath_tb_top
